// [core/phy_strap_and_mac_data_modes.sv]
// module: strap capture at reset and mii/rmii/smii data path toward the mac
`timescale 1ns/1ps
module phy_strap_and_mac_data_modes
import psm_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic refClk,
   // ----------------------------------------
   // chip pins sampled as levels
   // ----------------------------------------
   input wire logic chipResetN,
   input wire logic powerDownN,
   input wire logic [4:0] mgmtAddressStrap,
   input wire logic pcsLoopbackStrap,
   input wire logic serialModeStrap,
   input wire logic isolateStrap,
   input wire logic reducedModeStrap,
   input wire logic backToBackStrap,
   input wire logic speedStrap,
   input wire logic duplexStrap,
   input wire logic autonegStrap,
   input wire logic fiberEnable,
   // ----------------------------------------
   // captured configuration, plus live power-down
   // ----------------------------------------
   output logic [4:0] mgmtAddress,
   output logic pcsLoopback,
   output logic serialMode,
   output logic reducedMode,
   output logic isolate,
   output logic backToBack,
   output logic fiberMode,
   output logic farEndFaultEn,
   output logic powerDown,
   output logic [15:0] ctrlReg,
   output logic [15:0] advReg,
   output logic strapsDone,
   // ----------------------------------------
   // mac link, all on refClk
   // ----------------------------------------
   output logic [3:0] rxd,
   output logic rxDv,
   output logic smiiRxd,
   output logic rxdOe,
   input wire logic [3:0] txd,
   input wire logic txEn,
   input wire logic smiiTxd,
   input wire logic smiiSync,
   // ----------------------------------------
   // phy core byte side, on refClk
   // ----------------------------------------
   input wire logic [7:0] rxByte,
   input wire logic rxByteValid,
   output logic rxByteTake,
   output logic [7:0] txByte,
   output logic txByteValid
);
   // ----------------------------------------
   // state of both domains
   // ----------------------------------------
   typedef struct packed {
      psm_state_t st;
      logic [11:0] lowCnt;
      logic [2:0] cnt;
      logic [13:0] cap;
      logic [13:0] cfg;
      logic run;
      logic pd;
      logic [4:0] addr;
      logic loop;
      logic serial;
      logic rmii;
      logic iso;
      logic btb;
      logic fiber;
      logic fef;
      logic [15:0] ctrl;
      logic [15:0] adv;
   } psm_core_t;

   typedef struct packed {
      logic [7:0] rxBuf;
      logic [1:0] rxPh;
      logic rxBusy;
      logic [3:0] rxd;
      logic rxDv;
      logic rxTake;
      logic [3:0] smIdx;
      logic [3:0] smRep;
      logic [9:0] smSeg;
      logic smiiRxd;
      logic oe;
      logic [7:0] txAcc;
      logic [1:0] txPh;
      logic [3:0] txRep;
      logic [7:0] txByte;
      logic txValid;
   } psm_link_t;

   psm_core_t c_ff;
   psm_core_t nxt_c;
   psm_link_t l_ff;
   psm_link_t nxt_l;
   logic [15:0] pinSync;
   logic [LINK_CFG_W-1:0] linkCfg;
   logic [9:0] txSeg;
   logic txSegValid;

   // ----------------------------------------
   // pin synchronisers, clk domain
   // ----------------------------------------
   // straps reset to their pulled defaults so nothing odd is seen before the first sample
   psm_sync #(.W(16), .INIT({2'b11, STRAP_DEF})) u_pin_sync (
      .clk(clk),
      .reset(reset),
      .dIn({powerDownN, chipResetN, fiberEnable, autonegStrap, duplexStrap, speedStrap,
            backToBackStrap, reducedModeStrap, isolateStrap, serialModeStrap, pcsLoopbackStrap,
            mgmtAddressStrap}),
      .dOut(pinSync)
   );

   // ----------------------------------------
   // strap capture state machine
   // ----------------------------------------
   // powerup samples straps after async reset; hold samples while chip reset is low
   always_comb
   begin
      logic [13:0] straps;
      logic rstN;
      logic spd;
      straps = pinSync[13:0];
      rstN = pinSync[14];
      spd = 1'b0;
      nxt_c = c_ff;
      nxt_c.pd = ~pinSync[15];
      case (c_ff.st)
         PSM_POWERUP:
         begin
            nxt_c.run = 1'b0;
            nxt_c.cap = straps;
            if (!rstN)
            begin
               nxt_c.st = PSM_HOLD;
               nxt_c.lowCnt = 12'h000;
            end
            else if (c_ff.cnt == 3'(POWERUP_CYC))
            begin
               nxt_c.cfg = straps;
               nxt_c.st = PSM_RUN;
               nxt_c.cnt = 3'h0;
            end
            else
            begin
               nxt_c.cnt = c_ff.cnt + 3'h1;
            end
         end
         PSM_HOLD:
         begin
            nxt_c.run = 1'b0;
            nxt_c.cap = straps;
            if (c_ff.lowCnt != 12'(RESET_MIN_CYC))
            begin
               nxt_c.lowCnt = c_ff.lowCnt + 12'h001;
            end
            if (rstN)
            begin
               // a pulse shorter than the minimum leaves the old capture in place
               if (c_ff.lowCnt == 12'(RESET_MIN_CYC))
               begin
                  nxt_c.cfg = c_ff.cap;
               end
               nxt_c.st = PSM_RUN;
               nxt_c.cnt = 3'h0;
            end
         end
         PSM_RUN:
         begin
            // cfg is frozen here; shared pins may toggle freely
            if (!rstN)
            begin
               nxt_c.st = PSM_HOLD;
               nxt_c.lowCnt = 12'h000;
               nxt_c.run = 1'b0;
            end
            else if (c_ff.cnt != 3'(SETTLE_CYC))
            begin
               // let the frozen config cross to refClk before run does
               nxt_c.cnt = c_ff.cnt + 3'h1;
            end
            else
            begin
               nxt_c.run = 1'b1;
            end
         end
         default:
         begin
            nxt_c.st = PSM_POWERUP;
            nxt_c.cnt = 3'h0;
            nxt_c.run = 1'b0;
         end
      endcase

      // decoded configuration, derived from the frozen straps, except ctrl power-down bit from the live pin
      nxt_c.addr = nxt_c.cfg[S_ADDR +: 5];
      nxt_c.loop = nxt_c.cfg[S_LOOP];
      nxt_c.serial = nxt_c.cfg[S_SERIAL];
      nxt_c.iso = nxt_c.cfg[S_ISO];
      nxt_c.rmii = nxt_c.cfg[S_RMII] & ~nxt_c.cfg[S_SERIAL];
      nxt_c.btb = nxt_c.cfg[S_BTB];
      nxt_c.fiber = nxt_c.cfg[S_FIBER];
      // fiber runs at 100 only, so the speed strap then steers far-end fault
      spd = nxt_c.fiber | nxt_c.cfg[S_SPD];
      nxt_c.fef = ~nxt_c.fiber | nxt_c.cfg[S_SPD];
      nxt_c.ctrl = 16'h0000;
      nxt_c.ctrl[CTRL_LOOP] = nxt_c.loop;
      nxt_c.ctrl[CTRL_SPEED] = spd;
      nxt_c.ctrl[CTRL_ANEG] = nxt_c.cfg[S_ANEG] & ~nxt_c.fiber;
      nxt_c.ctrl[CTRL_PD] = nxt_c.pd;
      nxt_c.ctrl[CTRL_ISO] = nxt_c.iso;
      nxt_c.ctrl[CTRL_DUPLEX] = nxt_c.cfg[S_DUP];
      nxt_c.adv = ADV_BASE;
      nxt_c.adv[ADV_10HD] = 1'b1;
      nxt_c.adv[ADV_10FD] = nxt_c.cfg[S_DUP];
      nxt_c.adv[ADV_100HD] = spd;
      nxt_c.adv[ADV_100FD] = spd & nxt_c.cfg[S_DUP];
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         c_ff <= '{st: PSM_POWERUP, lowCnt: 12'h000, cnt: 3'h0, cap: STRAP_DEF, cfg: STRAP_DEF,
                   run: 1'b0, pd: 1'b0, addr: 5'h01, loop: 1'b0, serial: 1'b0, rmii: 1'b0,
                   iso: 1'b0, btb: 1'b0, fiber: 1'b0, fef: 1'b1, ctrl: 16'h3100, adv: 16'h01E1};
      end
      else
      begin
         c_ff <= nxt_c;
      end
   end

   // ----------------------------------------
   // config crossing into refClk domain
   // ----------------------------------------
   // levels only; all but pd are stable before run rises, so skew between bits is harmless
   psm_sync #(.W(LINK_CFG_W), .INIT('0)) u_link_sync (
      .clk(refClk),
      .reset(reset),
      .dIn({c_ff.run, c_ff.pd, c_ff.ctrl[CTRL_SPEED], c_ff.iso, c_ff.serial, c_ff.rmii}),
      .dOut(linkCfg)
   );

   psm_seg_rx u_seg_rx (
      .refClk(refClk),
      .reset(reset),
      .serIn(smiiTxd),
      .segSync(smiiSync),
      .seg(txSeg),
      .segValid(txSegValid)
   );

   // ----------------------------------------
   // link data path, refClk domain
   // ----------------------------------------
   always_comb
   begin
      logic run;
      logic smii;
      logic rmii;
      logic ten;
      logic [1:0] lastPh;
      run = linkCfg[L_RUN] & ~linkCfg[L_PD];
      smii = linkCfg[L_SMII];
      rmii = linkCfg[L_RMII] & ~smii;
      ten = ~linkCfg[L_SPD];
      lastPh = rmii ? RMII_LAST : MII_LAST;
      nxt_l = l_ff;
      nxt_l.rxTake = 1'b0;
      nxt_l.txValid = 1'b0;
      if (!run)
      begin
         // quiet link during reset and power-down
         nxt_l.rxBusy = 1'b0;
         nxt_l.rxPh = 2'h0;
         nxt_l.txPh = 2'h0;
         nxt_l.smRep = 4'h0;
         nxt_l.txRep = 4'h0;
         nxt_l.smSeg = 10'h000;
      end
      else if (smii)
      begin
         // receive segment: a new byte loads only on the first of its repeats
         if (smiiSync)
         begin
            nxt_l.smIdx = 4'h0;
            if (l_ff.smRep == 4'h0)
            begin
               nxt_l.smSeg = 10'h000;
               if (rxByteValid)
               begin
                  nxt_l.smSeg[SEG_CRS] = 1'b1;
                  nxt_l.smSeg[SEG_DV] = 1'b1;
                  nxt_l.smSeg[SEG_DATA +: 8] = rxByte;
                  nxt_l.rxTake = 1'b1;
               end
            end
            nxt_l.smRep = (ten && l_ff.smRep != 4'(SEG_REPEAT - 1)) ? l_ff.smRep + 4'h1 : 4'h0;
         end
         else if (l_ff.smIdx != 4'(SEG_BITS - 1))
         begin
            nxt_l.smIdx = l_ff.smIdx + 4'h1;
         end
         // transmit segment: at 10 Mb/s only the first of each ten is used
         if (txSegValid)
         begin
            if (l_ff.txRep == 4'h0 && txSeg[SEG_TXEN])
            begin
               nxt_l.txByte = txSeg[SEG_DATA +: 8];
               nxt_l.txValid = 1'b1;
            end
            nxt_l.txRep = (ten && l_ff.txRep != 4'(SEG_REPEAT - 1)) ? l_ff.txRep + 4'h1 : 4'h0;
         end
      end
      else
      begin
         // receive: nibbles or dibits, low bits first
         if (!l_ff.rxBusy || l_ff.rxPh == lastPh)
         begin
            nxt_l.rxPh = 2'h0;
            nxt_l.rxBusy = rxByteValid;
            if (rxByteValid)
            begin
               nxt_l.rxBuf = rxByte;
               nxt_l.rxTake = 1'b1;
            end
         end
         else
         begin
            nxt_l.rxPh = l_ff.rxPh + 2'h1;
         end
         // transmit: data is ignored while enable is low
         if (txEn)
         begin
            if (rmii)
            begin
               nxt_l.txAcc[{l_ff.txPh, 1'b0} +: 2] = txd[1:0];
            end
            else
            begin
               nxt_l.txAcc[{l_ff.txPh[0], 2'b00} +: 4] = txd;
            end
            if (l_ff.txPh == lastPh)
            begin
               nxt_l.txPh = 2'h0;
               nxt_l.txByte = nxt_l.txAcc;
               nxt_l.txValid = 1'b1;
            end
            else
            begin
               nxt_l.txPh = l_ff.txPh + 2'h1;
            end
         end
         else
         begin
            nxt_l.txPh = 2'h0;
         end
      end

      // registered pin values
      nxt_l.rxDv = run & ~smii & nxt_l.rxBusy;
      nxt_l.rxd = 4'h0;
      if (nxt_l.rxDv && rmii)
      begin
         nxt_l.rxd = {2'b00, nxt_l.rxBuf[{nxt_l.rxPh, 1'b0} +: 2]};
      end
      else if (nxt_l.rxDv)
      begin
         nxt_l.rxd = nxt_l.rxBuf[{nxt_l.rxPh[0], 2'b00} +: 4];
      end
      nxt_l.smiiRxd = run & smii & nxt_l.smSeg[nxt_l.smIdx];
      // straps share these pins, so they float until capture is over
      nxt_l.oe = run & ~linkCfg[L_ISO];
   end

   always_ff @(posedge refClk or posedge reset)
   begin
      if (reset)
      begin
         l_ff <= '0;
      end
      else
      begin
         l_ff <= nxt_l;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign mgmtAddress = c_ff.addr;
   assign pcsLoopback = c_ff.loop;
   assign serialMode = c_ff.serial;
   assign reducedMode = c_ff.rmii;
   assign isolate = c_ff.iso;
   assign backToBack = c_ff.btb;
   assign fiberMode = c_ff.fiber;
   assign farEndFaultEn = c_ff.fef;
   assign powerDown = c_ff.pd;
   assign ctrlReg = c_ff.ctrl;
   assign advReg = c_ff.adv;
   assign strapsDone = c_ff.run;
   assign rxd = l_ff.rxd;
   assign rxDv = l_ff.rxDv;
   assign smiiRxd = l_ff.smiiRxd;
   assign rxdOe = l_ff.oe;
   assign rxByteTake = l_ff.rxTake;
   assign txByte = l_ff.txByte;
   assign txByteValid = l_ff.txValid;
endmodule : phy_strap_and_mac_data_modes

// [core/psm_pkg.sv]
// package: constants and state types of the strap capture and mac data mode block
package psm_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int RESET_MIN_US = 50;
   localparam int RESET_MIN_CYC = RESET_MIN_US * CLK_MHZ;
   localparam int POWERUP_CYC = 3;
   localparam int SETTLE_CYC = 4;
   // ----------------------------------------
   // strap vector layout and defaults
   // ----------------------------------------
   localparam int STRAP_W = 14;
   localparam int S_ADDR = 0;
   localparam int S_LOOP = 5;
   localparam int S_SERIAL = 6;
   localparam int S_ISO = 7;
   localparam int S_RMII = 8;
   localparam int S_BTB = 9;
   localparam int S_SPD = 10;
   localparam int S_DUP = 11;
   localparam int S_ANEG = 12;
   localparam int S_FIBER = 13;
   localparam logic [13:0] STRAP_DEF = 14'h1C01;
   // ----------------------------------------
   // control and advertisement bit positions
   // ----------------------------------------
   localparam int CTRL_LOOP = 14;
   localparam int CTRL_SPEED = 13;
   localparam int CTRL_ANEG = 12;
   localparam int CTRL_PD = 11;
   localparam int CTRL_ISO = 10;
   localparam int CTRL_DUPLEX = 8;
   localparam int ADV_100FD = 8;
   localparam int ADV_100HD = 7;
   localparam int ADV_10FD = 6;
   localparam int ADV_10HD = 5;
   localparam logic [15:0] ADV_BASE = 16'h0001;
   // ----------------------------------------
   // link framing
   // ----------------------------------------
   localparam int SEG_BITS = 10;
   localparam int SEG_REPEAT = 10;
   localparam int SEG_CRS = 0;
   localparam int SEG_DV = 1;
   localparam int SEG_TXEN = 1;
   localparam int SEG_DATA = 2;
   localparam logic [1:0] MII_LAST = 2'h1;
   localparam logic [1:0] RMII_LAST = 2'h3;
   localparam int L_RMII = 0;
   localparam int L_SMII = 1;
   localparam int L_ISO = 2;
   localparam int L_SPD = 3;
   localparam int L_PD = 4;
   localparam int L_RUN = 5;
   localparam int LINK_CFG_W = 6;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [2:0] {
      PSM_POWERUP = 3'h1,
      PSM_HOLD = 3'h2,
      PSM_RUN = 3'h4
   } psm_state_t;
endpackage : psm_pkg

// [core/psm_sync.sv]
// module: two-flop synchroniser for a vector of slow levels
`timescale 1ns/1ps
module psm_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [W-1:0] dIn,
   output logic [W-1:0] dOut
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } psm_sync_t;
   psm_sync_t q;
   psm_sync_t nxt_q;

   // first stage feeds only the second stage
   always_comb
   begin
      nxt_q.meta = dIn;
      nxt_q.stable = q.meta;
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         q <= {INIT, INIT};
      end
      else
      begin
         q <= nxt_q;
      end
   end

   assign dOut = q.stable;
endmodule : psm_sync

// [core/psm_seg_rx.sv]
// module: serial segment collector for the smii transmit line
`timescale 1ns/1ps
module psm_seg_rx
import psm_pkg::*;
(
   input wire logic refClk,
   input wire logic reset,
   input wire logic serIn,
   input wire logic segSync,
   output logic [9:0] seg,
   output logic segValid
);
   typedef struct packed {
      logic [9:0] sh;
      logic [3:0] idx;
      logic [9:0] seg;
      logic valid;
   } psm_segrx_t;
   psm_segrx_t q;
   psm_segrx_t nxt_q;

   // sync marks bit 0; idx parks at SEG_BITS so a partial segment is never reported
   always_comb
   begin
      logic [3:0] wr;
      wr = segSync ? 4'h0 : q.idx;
      nxt_q = q;
      nxt_q.valid = 1'b0;
      if (wr < 4'(SEG_BITS))
      begin
         nxt_q.sh[wr] = serIn;
         nxt_q.idx = wr + 4'h1;
         if (wr == 4'(SEG_BITS - 1))
         begin
            nxt_q.seg = {serIn, q.sh[8:0]};
            nxt_q.valid = 1'b1;
         end
      end
   end

   always_ff @(posedge refClk or posedge reset)
   begin
      if (reset)
      begin
         q <= '{sh: 10'h000, idx: 4'hA, seg: 10'h000, valid: 1'b0};
      end
      else
      begin
         q <= nxt_q;
      end
   end

   assign seg = q.seg;
   assign segValid = q.valid;
endmodule : psm_seg_rx

// [dv/psm_assertions.sv]
// checker: concurrent checks on the ports of the strap capture block
`timescale 1ns/1ps
module psm_chk
import psm_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic refClk,
   input wire logic powerDownN,
   input wire logic powerDown,
   input wire logic [4:0] mgmtAddress,
   input wire logic [15:0] ctrlReg,
   input wire logic [15:0] advReg,
   input wire logic strapsDone,
   input wire logic serialMode,
   input wire logic reducedMode,
   input wire logic isolate,
   input wire logic fiberMode,
   input wire logic farEndFaultEn,
   input wire logic rxDv,
   input wire logic rxdOe,
   input wire logic txEn,
   input wire logic rxByteTake,
   input wire logic txByteValid
);
   // ----------------------------------------
   // system clock side
   // ----------------------------------------
   // five samples leave room for the two-flop sync plus the output register
   a_pd_enter: assert property (@(posedge clk) disable iff (reset) (!powerDownN)[*5] |-> powerDown)
      else $error("power-down not entered");
   a_pd_leave: assert property (@(posedge clk) disable iff (reset) powerDownN[*5] |-> !powerDown)
      else $error("power-down not left");
   a_adv_speed: assert property (@(posedge clk) disable iff (reset) advReg[ADV_100HD] == ctrlReg[CTRL_SPEED])
      else $error("speed advertisement differs from control");
   a_adv_duplex: assert property (@(posedge clk) disable iff (reset) advReg[ADV_10FD] == ctrlReg[CTRL_DUPLEX])
      else $error("duplex advertisement differs from control");
   a_fiber_fef: assert property (@(posedge clk) disable iff (reset) !fiberMode |-> farEndFaultEn)
      else $error("far-end fault off without fiber");
   a_fiber_aneg: assert property (@(posedge clk) disable iff (reset) fiberMode |-> !ctrlReg[CTRL_ANEG])
      else $error("autoneg on in fiber mode");
   a_mode_excl: assert property (@(posedge clk) disable iff (reset) !(serialMode && reducedMode))
      else $error("serial and reduced mode together");
   a_cfg_hold: assert property (@(posedge clk) disable iff (reset)
      strapsDone && $past(strapsDone) |-> $stable(mgmtAddress) && $stable(ctrlReg[14:12]) && $stable(isolate))
      else $error("captured config moved in run");
   // ----------------------------------------
   // link clock side
   // ----------------------------------------
   a_iso_quiet: assert property (@(posedge refClk) disable iff (reset) isolate[*4] |-> !rxdOe)
      else $error("link driven while isolated");
   a_take_dv: assert property (@(posedge refClk) disable iff (reset) rxByteTake && !serialMode |-> rxDv)
      else $error("byte taken without receive valid");
   a_take_gap: assert property (@(posedge refClk) disable iff (reset) rxByteTake |=> !rxByteTake)
      else $error("byte taken on two edges in a row");
   a_tx_en: assert property (@(posedge refClk) disable iff (reset) txByteValid && !serialMode |-> $past(txEn))
      else $error("transmit byte without enable");
   // main scenarios reached
   c_done: cover property (@(posedge clk) $rose(strapsDone));
   c_take: cover property (@(posedge refClk) rxByteTake);
   c_tx: cover property (@(posedge refClk) txByteValid);
endmodule : psm_chk

bind phy_strap_and_mac_data_modes psm_chk psm_chk_inst (.*);

// [dv/psm_mac_model.sv]
// partner: mac side of the mii transmit path
`timescale 1ns/1ps
module psm_mac_model
(
   input wire logic refClk,
   output logic [3:0] txd,
   output logic txEn
);
   // idle until asked to send
   initial
   begin
      txEn = 1'b0;
      txd = 4'h0;
   end

   // low nibble first; after release the nibble is inverted so stale data never looks valid
   task automatic send(input logic [7:0] b);
      @(posedge refClk);
      #2;
      txEn = 1'b1;
      txd = b[3:0];
      @(posedge refClk);
      #2;
      txd = b[7:4];
      @(posedge refClk);
      #2;
      txEn = 1'b0;
      txd = ~b[7:4];
   endtask : send
endmodule : psm_mac_model

// [dv/phy_strap_and_mac_data_modes_tb.sv]
// testbench: strap capture and mii data paths
`timescale 1ns/1ps
module phy_strap_and_mac_data_modes_tb
import psm_pkg::*;
;
   typedef struct packed {logic [13:0] s; logic [4:0] a; logic [7:0] m; logic [15:0] c; logic [15:0] v;} psm_row_t;
   logic clk = 1'b0;
   logic refClk = 1'b0;
   logic reset = 1'b1;
   logic chipResetN = 1'b1;
   logic powerDownN = 1'b1;
   logic [13:0] straps = STRAP_DEF;
   logic [7:0] rxByte = 8'h00;
   logic rxByteValid = 1'b0;
   logic [4:0] mgmtAddress;
   logic pcsLoopback, serialMode, reducedMode, isolate, backToBack, fiberMode, farEndFaultEn, powerDown;
   logic [15:0] ctrlReg, advReg;
   logic strapsDone, rxDv, rxdOe, txEn, rxByteTake, txByteValid;
   logic [3:0] rxd, txd;
   logic [7:0] txByte, txLast;
   int num_errors = 0;
   int comparisons = 0;
   int txSeen = 0;
   psm_row_t rows [3];

   always #12.5 clk = ~clk;
   always #40 refClk = ~refClk;

   phy_strap_and_mac_data_modes phy_strap_and_mac_data_modes_inst (
      .clk(clk), .reset(reset), .refClk(refClk), .chipResetN(chipResetN), .powerDownN(powerDownN),
      .mgmtAddressStrap(straps[4:0]), .pcsLoopbackStrap(straps[5]), .serialModeStrap(straps[6]),
      .isolateStrap(straps[7]), .reducedModeStrap(straps[8]), .backToBackStrap(straps[9]),
      .speedStrap(straps[10]), .duplexStrap(straps[11]), .autonegStrap(straps[12]), .fiberEnable(straps[13]),
      .mgmtAddress(mgmtAddress), .pcsLoopback(pcsLoopback), .serialMode(serialMode), .reducedMode(reducedMode),
      .isolate(isolate), .backToBack(backToBack), .fiberMode(fiberMode), .farEndFaultEn(farEndFaultEn),
      .powerDown(powerDown), .ctrlReg(ctrlReg), .advReg(advReg), .strapsDone(strapsDone),
      .rxd(rxd), .rxDv(rxDv), .smiiRxd(), .rxdOe(rxdOe), .txd(txd), .txEn(txEn), .smiiTxd(1'b0),
      .smiiSync(1'b0), .rxByte(rxByte), .rxByteValid(rxByteValid), .rxByteTake(rxByteTake),
      .txByte(txByte), .txByteValid(txByteValid));

   psm_mac_model psm_mac_model_inst (.refClk(refClk), .txd(txd), .txEn(txEn));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // transmit pulses last one link cycle, so they are caught here
   always @(posedge refClk)
   begin
      if (txByteValid === 1'b1)
      begin
         txSeen++;
         txLast = txByte;
      end
   end

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // bounded wait for the frozen config, then let it reach the link domain
   task automatic wait_done();
      int k;
      k = 0;
      while (strapsDone !== 1'b1 && k < 200)
      begin
         @(posedge clk);
         k++;
      end
      cmp({15'h0, strapsDone}, 16'h0001);
      repeat (4) @(posedge refClk);
      #3;
   endtask : wait_done

   task automatic chip_pulse(input int n);
      @(posedge clk);
      #2;
      chipResetN = 1'b0;
      repeat (n) @(posedge clk);
      #2;
      chipResetN = 1'b1;
      wait_done();
   endtask : chip_pulse

   task automatic end_of_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test

   // watchdog, several times the expected run
   initial
   begin
      #400000;
      num_errors++;
      end_of_test();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      int k;
      rows[0] = '{14'h03BE, 5'h1E, 8'hBA, 16'h4400, 16'h0021};
      rows[1] = '{14'h3940, 5'h00, 8'h45, 16'h2100, 16'h01E1};
      rows[2] = '{STRAP_DEF, 5'h01, 8'h03, 16'h3100, 16'h01E1};
      // one reset per strap setting, the default one last so mii tests follow
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk);
         #2;
         straps = rows[i].s;
         reset = 1'b1;
         repeat (i == 0 ? 3 : 4) @(posedge clk);
         #2;
         reset = 1'b0;
         wait_done();
         cmp({11'h0, mgmtAddress}, {11'h0, rows[i].a});
         cmp({8'h0, pcsLoopback, serialMode, reducedMode, isolate, backToBack, fiberMode, farEndFaultEn, rxdOe},
            {8'h0, rows[i].m});
         cmp(ctrlReg, rows[i].c);
         cmp(advReg, rows[i].v);
      end
      // straps moving in run must not reach the config
      straps = 14'h03BE;
      repeat (20) @(posedge clk);
      cmp({11'h0, mgmtAddress}, 16'h0001);
      cmp(ctrlReg, 16'h3100);
      // mii receive: one byte, low nibble first
      @(posedge refClk);
      #2;
      rxByte = 8'hA5;
      rxByteValid = 1'b1;
      k = 0;
      while (rxByteTake !== 1'b1 && k < 20)
      begin
         @(posedge refClk);
         #1;
         k++;
      end
      #1;
      rxByteValid = 1'b0;
      rxByte = 8'h5A;
      cmp({12'h0, rxd}, 16'h0005);
      cmp({15'h0, rxDv}, 16'h0001);
      @(posedge refClk);
      #2;
      cmp({12'h0, rxd}, 16'h000A);
      @(posedge refClk);
      #2;
      cmp({15'h0, rxDv}, 16'h0000);
      // mii transmit, then idle data with enable low must give nothing
      psm_mac_model_inst.send(8'h3C);
      repeat (4) @(posedge refClk);
      cmp(txSeen[15:0], 16'h0001);
      cmp({8'h0, txLast}, 16'h003C);
      // power-down is live, not captured
      @(posedge clk);
      #2;
      powerDownN = 1'b0;
      repeat (6) @(posedge clk);
      cmp({14'h0, powerDown, ctrlReg[CTRL_PD]}, 16'h0003);
      #2;
      powerDownN = 1'b1;
      repeat (6) @(posedge clk);
      cmp({15'h0, powerDown}, 16'h0000);
      // short chip reset keeps the old capture, a 52.5 us one takes the new straps
      chip_pulse(100);
      cmp({11'h0, mgmtAddress}, 16'h0001);
      chip_pulse(2100);
      cmp({11'h0, mgmtAddress}, 16'h001E);
      cmp(ctrlReg, 16'h4400);
      // rmii is now captured: one byte leaves as four dibits, low pair first
      @(posedge refClk);
      #2;
      rxByte = 8'hB4;
      rxByteValid = 1'b1;
      @(posedge refClk);
      #2;
      rxByteValid = 1'b0;
      cmp({11'h0, rxDv, rxd}, 16'h0010);
      @(posedge refClk);
      #2;
      cmp({11'h0, rxDv, rxd}, 16'h0011);
      @(posedge refClk);
      #2;
      cmp({11'h0, rxDv, rxd}, 16'h0013);
      end_of_test();
   end
endmodule : phy_strap_and_mac_data_modes_tb
